// ==== include/htqf_consts.svh ====
// constants for the host transmit queue fetch block
`ifndef HTQF_CONSTS_SVH
`define HTQF_CONSTS_SVH

`define HTQF_ADDR_W 8
`define HTQF_SEGMENTATION_CONTROL_OFS 8'h20
`define HTQF_DOORBELL_OFS 8'h40
`define HTQF_SEGMENTATION_CONTROL_RST 32'h0000_0000
`define HTQF_SIZE_SEL_HI 11
`define HTQF_SIZE_SEL_LO 10
`define HTQF_PEND_HI 29
`define HTQF_PEND_LO 16
`define HTQF_OVF_BIT 30
`define HTQF_ADD_HI 13
`define HTQF_IDX_W 14
`define HTQF_CNT_W 15
`define HTQF_DESC_W 32
`define HTQF_SIZE_256 15'h0100
`define HTQF_SIZE_1K 15'h0400
`define HTQF_SIZE_4K 15'h1000
`define HTQF_SIZE_16K 15'h4000
`define HTQF_SLOT_CYCLES 150
`define HTQF_SLOT_LAST 8'h95
`define HTQF_SLOT_W 8

`endif

// ==== include/htqf_pkg.sv ====
// types shared by the host transmit queue fetch block
`include "htqf_consts.svh"

package htqf_pkg;

  typedef enum logic [0:0] {
    HTQF_IDLE = 1'b0,
    HTQF_FETCH = 1'b1
  } htqf_fsm_t;

  typedef struct packed {
    logic [`HTQF_SLOT_W-1:0] cnt;
    logic tick;
  } htqf_timer_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [`HTQF_CNT_W-1:0] pending;
    logic [`HTQF_IDX_W-1:0] rd_idx;
    htqf_fsm_t fsm;
    logic credit;
    logic chain_wr;
    logic [`HTQF_IDX_W-1:0] chain_index;
    logic [`HTQF_DESC_W-1:0] chain_data;
    logic [31:0] rdata;
  } htqf_state_t;

endpackage

// ==== logic/htqf_slot_timer.sv ====
// cell slot pacer: one tick every cell slot
`timescale 1ns/1ps
`default_nettype none
`include "htqf_consts.svh"

module htqf_slot_timer (
  input wire logic clk, // core clock
  input wire logic sys_rst, // synchronous reset, high
  output logic slot_tick // one-cycle pulse per cell slot
);
  import htqf_pkg::*;

  htqf_timer_t cur;
  htqf_timer_t nxt;

  always_comb begin
    nxt = cur;
    nxt.tick = 1'b0;
    if (cur.cnt == `HTQF_SLOT_LAST) begin
      nxt.cnt = '0;
      nxt.tick = 1'b1;
    end else begin
      nxt.cnt = cur.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign slot_tick = cur.tick;

endmodule // htqf_slot_timer
`default_nettype wire

// ==== logic/htqf_top.sv ====
// host transmit queue fetch: doorbell, pending count and paced descriptor copy
// Operation
// - a doorbell write at 0x40 starts fetching and consuming pending entries
// - each host queue slot holds one buffer descriptor ready for segmentation
// - entries are consumed at about one per cell slot, whatever the buffer length
// - a cell slot lasts about 150 core clock periods
// - doorbell read shows the low 14 bits of the pending entry count in bits 29 to 16
// - pending equal to the configured queue size means the queue is full
// - queue depth comes from bits 11 and 10 of segmentation control at 0x20
// - depth codes: 00=256, 01=1024, 10=4096, 11=16384 entries
// - slots fill in ascending order and wrap to the first after the last
// - a slot is free once copied to the local chain, before segmentation
`timescale 1ns/1ps
`default_nettype none
`include "htqf_consts.svh"

module htqf_top (
  input wire logic clk, // core clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic [`HTQF_ADDR_W-1:0] reg_addr, // register byte offset
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [31:0] reg_wdata, // register write data
  output logic [31:0] reg_rdata, // register read data, next cycle
  output logic fetch_req, // request host read of one slot
  output logic [`HTQF_IDX_W-1:0] fetch_index, // host slot to read
  input wire logic fetch_ack, // host slot data valid
  input wire logic [`HTQF_DESC_W-1:0] fetch_data, // host slot descriptor
  output logic chain_wr, // write descriptor to local chain
  output logic [`HTQF_IDX_W-1:0] chain_index, // slot the descriptor came from
  output logic [`HTQF_DESC_W-1:0] chain_data, // descriptor copied
  output logic queue_full // pending equals queue size
);
  import htqf_pkg::*;

  htqf_state_t cur;
  htqf_state_t nxt;
  logic slot_tick;
  logic [`HTQF_CNT_W-1:0] q_size;
  logic [`HTQF_IDX_W-1:0] idx_mask;
  logic db_wr;
  logic copy;
  logic [`HTQF_CNT_W:0] sum;

  htqf_slot_timer u_slot (
    .clk(clk),
    .sys_rst(sys_rst),
    .slot_tick(slot_tick)
  );

  always_comb begin
    case (cur.ctrl[`HTQF_SIZE_SEL_HI:`HTQF_SIZE_SEL_LO])
      2'b00: q_size = `HTQF_SIZE_256;
      2'b01: q_size = `HTQF_SIZE_1K;
      2'b10: q_size = `HTQF_SIZE_4K;
      2'b11: q_size = `HTQF_SIZE_16K;
      default: q_size = `HTQF_SIZE_256;
    endcase
  end

  // sizes are powers of two, so the low bits of size-1 form the wrap mask
  assign idx_mask = q_size[`HTQF_IDX_W-1:0] - 14'h0001;
  assign db_wr = reg_wr && (reg_addr == `HTQF_DOORBELL_OFS);
  assign copy = (cur.fsm == HTQF_FETCH) && fetch_ack;
  // the count written with the doorbell is added; a copy removes one
  assign sum = {1'b0, cur.pending}
             + (db_wr ? {2'b00, reg_wdata[`HTQF_ADD_HI:0]} : 16'h0000)
             - {15'h0000, copy};

  always_comb begin
    nxt = cur;
    nxt.chain_wr = 1'b0;
    case (cur.fsm)
      HTQF_IDLE: begin
        if (cur.credit && (cur.pending != '0)) begin
          nxt.fsm = HTQF_FETCH;
          nxt.credit = 1'b0;
        end
      end
      HTQF_FETCH: begin
        if (fetch_ack) begin
          nxt.chain_wr = 1'b1;
          nxt.chain_index = cur.rd_idx;
          nxt.chain_data = fetch_data;
          nxt.rd_idx = (cur.rd_idx + 14'h0001) & idx_mask;
          nxt.fsm = HTQF_IDLE;
        end
      end
      default: nxt.fsm = HTQF_IDLE;
    endcase
    // a tick that lands on the cycle the credit is spent is kept
    if (slot_tick) begin
      nxt.credit = 1'b1;
    end
    // pending never passes the queue size; extra doorbell counts are dropped
    if (sum > {1'b0, q_size}) begin
      nxt.pending = q_size;
    end else begin
      nxt.pending = sum[`HTQF_CNT_W-1:0];
    end
    if (reg_wr && (reg_addr == `HTQF_SEGMENTATION_CONTROL_OFS)) begin
      nxt.ctrl = reg_wdata;
    end
    // a smaller size chosen on the fly pulls the index back inside the ring
    if (cur.fsm != HTQF_FETCH) begin
      nxt.rd_idx = nxt.rd_idx & idx_mask;
    end
    if (reg_rd) begin
      if (reg_addr == `HTQF_SEGMENTATION_CONTROL_OFS) begin
        nxt.rdata = cur.ctrl;
      end else if (reg_addr == `HTQF_DOORBELL_OFS) begin
        nxt.rdata = '0;
        nxt.rdata[`HTQF_PEND_HI:`HTQF_PEND_LO] = cur.pending[`HTQF_IDX_W-1:0];
        nxt.rdata[`HTQF_OVF_BIT] = (cur.pending == q_size);
      end else begin
        nxt.rdata = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur <= '0;
      cur.ctrl <= `HTQF_SEGMENTATION_CONTROL_RST;
    end else begin
      cur <= nxt;
    end
  end

  assign reg_rdata = cur.rdata;
  assign fetch_req = (cur.fsm == HTQF_FETCH);
  assign fetch_index = cur.rd_idx;
  assign chain_wr = cur.chain_wr;
  assign chain_index = cur.chain_index;
  assign chain_data = cur.chain_data;
  assign queue_full = (cur.pending == q_size);

  sequence s_db_write;
    db_wr && !copy && (sum <= {1'b0, q_size});
  endsequence

  sequence s_copy;
    fetch_req && fetch_ack && !db_wr;
  endsequence

  property p_doorbell_add;
    @(posedge clk) disable iff (sys_rst)
    s_db_write |=> (cur.pending == $past(cur.pending) + {1'b0, $past(reg_wdata[`HTQF_ADD_HI:0])});
  endproperty
  a_doorbell_add: assert property (p_doorbell_add) else $error("doorbell count not added");

  property p_copy_dec;
    @(posedge clk) disable iff (sys_rst)
    s_copy |=> chain_wr && (chain_data == $past(fetch_data)) && (cur.pending == $past(cur.pending) - 15'h0001);
  endproperty
  a_copy_dec: assert property (p_copy_dec) else $error("copy did not write chain or drop pending");

  property p_fetch_on_credit;
    @(posedge clk) disable iff (sys_rst)
    $rose(fetch_req) |-> $past(cur.credit) && ($past(cur.pending) != '0);
  endproperty
  a_fetch_on_credit: assert property (p_fetch_on_credit) else $error("fetch started without slot credit");

  property p_tick_credit;
    @(posedge clk) disable iff (sys_rst)
    slot_tick |=> cur.credit;
  endproperty
  a_tick_credit: assert property (p_tick_credit) else $error("slot tick lost");

  property p_tick_period;
    @(posedge clk) disable iff (sys_rst)
    slot_tick |=> !slot_tick [*8] ##142 slot_tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("cell slot period wrong");

  property p_read_pending;
    @(posedge clk) disable iff (sys_rst)
    reg_rd && (reg_addr == `HTQF_DOORBELL_OFS) |=>
      (reg_rdata[`HTQF_PEND_HI:`HTQF_PEND_LO] == $past(cur.pending[`HTQF_IDX_W-1:0]))
      && (reg_rdata[31] == 1'b0);
  endproperty
  a_read_pending: assert property (p_read_pending) else $error("pending readback wrong");

  property p_not_over;
    @(posedge clk) disable iff (sys_rst)
    cur.pending <= q_size;
  endproperty
  a_not_over: assert property (p_not_over) else $error("pending above queue size");

  property p_size_max;
    @(posedge clk) disable iff (sys_rst)
    reg_wr && (reg_addr == `HTQF_SEGMENTATION_CONTROL_OFS) && (reg_wdata[11:10] == 2'b11) |=> (idx_mask == 14'h3fff);
  endproperty
  a_size_max: assert property (p_size_max) else $error("size select not applied");

  property p_idx_wrap;
    @(posedge clk) disable iff (sys_rst)
    s_copy ##0 ((cur.rd_idx == idx_mask) && !(reg_wr && (reg_addr == `HTQF_SEGMENTATION_CONTROL_OFS)))
      |=> (cur.rd_idx == '0);
  endproperty
  a_idx_wrap: assert property (p_idx_wrap) else $error("read index did not wrap");

  // the host may take many cycles to answer, so the request must not move meanwhile
  property p_fetch_hold;
    @(posedge clk) disable iff (sys_rst)
    fetch_req && !fetch_ack |=> fetch_req && $stable(fetch_index);
  endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch request dropped or index moved");

  property p_chain_pulse;
    @(posedge clk) disable iff (sys_rst)
    chain_wr |=> !chain_wr;
  endproperty
  a_chain_pulse: assert property (p_chain_pulse) else $error("chain write longer than one cycle");

  property p_rdata_hold;
    @(posedge clk) disable iff (sys_rst)
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read");

endmodule // htqf_top
`default_nettype wire

// ==== dv/htqf_host_model.sv ====
// host memory model that answers slot reads for the transmit queue
`timescale 1ns/1ps
`default_nettype none
`include "htqf_consts.svh"

module htqf_host_model (
  input wire logic clk, // core clock
  input wire logic fetch_req, // slot read request
  input wire logic [`HTQF_IDX_W-1:0] fetch_index, // slot asked for
  input wire logic [3:0] wait_cycles, // answer delay in cycles
  output logic fetch_ack, // slot data valid
  output logic [`HTQF_DESC_W-1:0] fetch_data // slot descriptor
);
  logic [3:0] cnt = 4'h0;
  initial fetch_ack = 1'b0;
  initial fetch_data = 32'h0;
  always @(negedge clk) begin
    if (fetch_ack || !fetch_req) begin
      fetch_ack <= 1'b0;
      // released bus toggles so a stale descriptor can never look valid
      fetch_data <= ~fetch_data;
      cnt <= 4'h0;
    end else if (cnt == wait_cycles) begin
      fetch_ack <= 1'b1;
      fetch_data <= 32'hd0c0_0000 | 32'(fetch_index);
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule // htqf_host_model
`default_nettype wire

// ==== dv/htqf_top_tb.sv ====
// self-checking bench for the host transmit queue fetch block
`timescale 1ns/1ps
`default_nettype none
`include "htqf_consts.svh"

module htqf_top_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, chain_data, fetch_data, rd, sz;
  logic [13:0] fetch_index, chain_index;
  logic fetch_req, fetch_ack, chain_wr, queue_full;
  logic [3:0] host_wait = 4'h0;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int last = 0;
  always #20 clk = ~clk;

  htqf_top htqf_top_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fetch_req(fetch_req),
    .fetch_index(fetch_index), .fetch_ack(fetch_ack), .fetch_data(fetch_data), .chain_wr(chain_wr),
    .chain_index(chain_index), .chain_data(chain_data), .queue_full(queue_full));
  htqf_host_model htqf_host_model_inst (.clk(clk), .fetch_req(fetch_req), .fetch_index(fetch_index),
    .wait_cycles(host_wait), .fetch_ack(fetch_ack), .fetch_data(fetch_data));

  task automatic close_out();
    $display("counts: %0d checks, %0d mismatches", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ring wrap alone needs 257 slots of 150 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    rd = reg_rdata;
  endtask

  task automatic wait_copy();
    int n;
    n = 0;
    @(negedge clk);
    while (chain_wr !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk("copy seen", 32'h1, {31'h0, chain_wr});
  endtask

  initial begin
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
    rdr(8'h20);
    chk("control reset", 32'h0, rd);
    rdr(8'h40);
    chk("doorbell reset", 32'h0, rd);
    chk("empty pin", 32'h0, {31'h0, queue_full});
    wr(8'h44, 32'hffff_ffff);
    rdr(8'h44);
    chk("unmapped read", 32'h0, rd);
    rdr(8'h20);
    chk("control kept", 32'h0, rd);
    wr(8'h40, 32'h3);
    wr(8'h40, 32'hffff_c000);
    rdr(8'h40);
    chk("pending three", 32'h0003_0000, rd);
    wr(8'h40, 32'hff);
    rdr(8'h40);
    chk("pending clipped", 32'h4100_0000, rd);
    chk("full pin", 32'h1, {31'h0, queue_full});
    $display("test registers done");
    for (int k = 0; k < 257; k++) begin
      wait_copy();
      chk("copy index", 32'(k % 256), {18'h0, chain_index});
      chk("copy data", 32'hd0c0_0000 | 32'(k % 256), chain_data);
      if (k > 0) chk("slot spacing", 32'd150, 32'(cyc - last));
      last = cyc;
      if (k == 0) wr(8'h40, 32'h1);
    end
    rdr(8'h40);
    chk("drained", 32'h0, rd);
    chk("empty pin after drain", 32'h0, {31'h0, queue_full});
    $display("test ring wrap done");
    host_wait = 4'h9;
    for (int c = 1; c < 4; c++) begin
      sz = 32'h100 << (2 * c);
      wr(8'h20, 32'(c) << 10);
      rdr(8'h20);
      chk("control readback", 32'(c) << 10, rd);
      wr(8'h40, 32'h3fff);
      wr(8'h40, 32'h3fff);
      wait_copy();
      chk("size copy index", 32'(c), {18'h0, chain_index});
      rdr(8'h40);
      chk("pending after copy", ((sz - 1) & 32'h3fff) << 16, rd);
      wr(8'h40, 32'h1);
      rdr(8'h40);
      chk("full at size", 32'h4000_0000 | ((sz & 32'h3fff) << 16), rd);
      chk("full pin size", 32'h1, {31'h0, queue_full});
    end
    $display("test sizes done");
    close_out();
  end
endmodule // htqf_top_tb
`default_nettype wire
